//--- rtl/serializer_main_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module serializer_main_config_regs
    import main_cfg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [6:0] address_strap_pin_in,
    input wire logic voltage_strap_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    output logic [6:0] active_bus_address_out,
    output logic address_valid_out,
    output logic rom_reload_request_out,
    output logic register_reset_out,
    output logic logic_reset_out,
    output logic clock_lane_always_on_out,
    output logic [1:0] lane_select_out,
    output logic tx_check_code_enable_out,
    output logic bus_voltage_low_out
);
    logic [7:0] strap_value;
    logic strap_valid;
    logic strap_loaded_reg;
    logic address_override_enable_reg;
    logic [6:0] own_bus_address_field_reg;
    logic [7:0] reset_control_reg;
    logic [7:0] general_cfg_reg;
    logic [7:0] rdata_next;
    logic regs_clear;
    logic wr_addr;
    logic wr_reset;
    logic wr_cfg;

    strap_capture #(
        .width(8)
    ) strap_unit (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .strap_in({voltage_strap_in, address_strap_pin_in}),
        .value_out(strap_value),
        .valid_out(strap_valid)
    );

    assign wr_addr = reg_write_in && reg_addr_in == own_addr_offset;
    assign wr_reset = reg_write_in && reg_addr_in == reset_control_offset;
    assign wr_cfg = reg_write_in && reg_addr_in == general_cfg_offset;
    // full reset pulse returns registers to defaults; straps reapply
    assign regs_clear = rst_in || reset_control_reg[full_reset_bit];

    always_ff @(posedge clk_in) begin
        if (regs_clear) begin
            strap_loaded_reg <= 1'b0;
            address_override_enable_reg <= override_reset;
            own_bus_address_field_reg <= 7'h00;
        end else begin
            if (strap_valid && !strap_loaded_reg) begin
                strap_loaded_reg <= 1'b1;
                own_bus_address_field_reg <= strap_value[6:0];
            end else if (wr_addr) begin
                address_override_enable_reg <= reg_wdata_in[override_bit];
                // address bits are only writable while override is on
                if (address_override_enable_reg) begin
                    own_bus_address_field_reg <= reg_wdata_in[7:addr_lsb];
                end
            end
            // dropping override snaps back to the strapped address
            if (!address_override_enable_reg && strap_loaded_reg) begin
                own_bus_address_field_reg <= strap_value[6:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reset_control_reg <= 8'h00;
        // a write landing on the full reset pulse is lost; registers are clearing anyway
        end else if (wr_reset && !reset_control_reg[full_reset_bit]) begin
            reset_control_reg <= {5'h00, reg_wdata_in[2:0]};
        end else begin
            reset_control_reg <= 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (regs_clear) begin
            general_cfg_reg <= 8'h00;
            general_cfg_reg[clock_lane_bit] <= clock_lane_reset;
            general_cfg_reg[lane_lsb +: 2] <= lanes_reset;
            general_cfg_reg[check_code_bit] <= check_code_reset;
        end else if (strap_valid && !strap_loaded_reg) begin
            general_cfg_reg[voltage_bit] <= strap_value[7];
        end else if (wr_cfg) begin
            general_cfg_reg <= reg_wdata_in;
        end
    end

    always_comb begin
        rdata_next = unmapped_value;
        case (reg_addr_in)
            own_addr_offset: begin
                rdata_next = {own_bus_address_field_reg, address_override_enable_reg};
            end
            reset_control_offset: begin
                rdata_next = reset_control_reg;
            end
            general_cfg_offset: begin
                rdata_next = general_cfg_reg;
            end
            default: begin
                rdata_next = unmapped_value;
            end
        endcase
    end

    // no read-to-clear or latched fields live in this bank
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_read_in) begin
            reg_rdata_out <= rdata_next;
        end
    end

    assign active_bus_address_out = own_bus_address_field_reg;
    assign address_valid_out = strap_loaded_reg;
    assign rom_reload_request_out = reset_control_reg[reload_bit];
    assign register_reset_out = reset_control_reg[full_reset_bit];
    assign logic_reset_out = reset_control_reg[soft_reset_bit] || reset_control_reg[full_reset_bit];
    assign clock_lane_always_on_out = general_cfg_reg[clock_lane_bit];
    assign lane_select_out = general_cfg_reg[lane_lsb +: 2];
    assign tx_check_code_enable_out = general_cfg_reg[check_code_bit];
    assign bus_voltage_low_out = general_cfg_reg[voltage_bit];

    // a fresh reload write may legally follow the pulse at once
    chk_selfclear_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        rom_reload_request_out && !wr_reset
        |=> !rom_reload_request_out)
        else $error("reload request lasted more than one cycle");
    chk_reload_from_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_reset && reg_wdata_in[reload_bit] && !register_reset_out
        |=> rom_reload_request_out)
        else $error("reload request not raised after write");
    chk_full_reset_defaults: assert property (@(posedge clk_in) disable iff (rst_in)
        register_reset_out |=> lane_select_out == lanes_reset && tx_check_code_enable_out
        && !clock_lane_always_on_out && !address_override_enable_reg)
        else $error("full reset left registers altered");
    chk_soft_keeps_regs: assert property (@(posedge clk_in) disable iff (rst_in)
        logic_reset_out && !register_reset_out && !wr_cfg
        |=> $stable(general_cfg_reg))
        else $error("logic reset changed registers");
    chk_full_dominates: assert property (@(posedge clk_in) disable iff (rst_in)
        register_reset_out
        |-> logic_reset_out)
        else $error("full reset without logic reset");
    chk_addr_locked: assert property (@(posedge clk_in) disable iff (rst_in)
        strap_loaded_reg && !address_override_enable_reg && !register_reset_out
        |=> active_bus_address_out == strap_value[6:0])
        else $error("address differs from strap without override");
    chk_addr_override: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_addr && address_override_enable_reg && !register_reset_out
        |=> active_bus_address_out == $past(reg_wdata_in[7:1]))
        else $error("override write not applied");
    chk_cfg_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_cfg && !register_reset_out && strap_loaded_reg
        |=> lane_select_out == $past(reg_wdata_in[5:4])
        && bus_voltage_low_out == $past(reg_wdata_in[0]))
        else $error("configuration write not applied");
    chk_reload_needs_write: assert property (@(posedge clk_in) disable iff (rst_in)
        !(wr_reset && reg_wdata_in[reload_bit])
        |=> !rom_reload_request_out)
        else $error("reload request raised without a write");
    chk_soft_only_logic: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_reset && reg_wdata_in[soft_reset_bit] && !reg_wdata_in[full_reset_bit]
        && !register_reset_out |=> logic_reset_out && !register_reset_out)
        else $error("logic reset write not applied alone");
    chk_both_full_wins: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_reset && reg_wdata_in[soft_reset_bit] && reg_wdata_in[full_reset_bit]
        && !register_reset_out |=> register_reset_out
        ##1 lane_select_out == lanes_reset && !address_override_enable_reg)
        else $error("both reset bits did not apply the full reset");
    chk_full_clears_address: assert property (@(posedge clk_in) disable iff (rst_in)
        register_reset_out
        |=> !address_valid_out && active_bus_address_out == 7'h00)
        else $error("full reset kept the address");
    chk_strap_load: assert property (@(posedge clk_in) disable iff (rst_in)
        strap_valid && !strap_loaded_reg && !register_reset_out
        |=> address_valid_out && active_bus_address_out == $past(strap_value[6:0])
        && bus_voltage_low_out == $past(strap_value[7]))
        else $error("strap values not loaded");
    chk_read_address: assert property (@(posedge clk_in) disable iff (rst_in)
        reg_read_in && reg_addr_in == own_addr_offset
        |=> reg_rdata_out[7:1] == $past(active_bus_address_out)
        && reg_rdata_out[0] == $past(address_override_enable_reg))
        else $error("address read does not show the address in use");
    chk_read_config: assert property (@(posedge clk_in) disable iff (rst_in)
        reg_read_in && reg_addr_in == general_cfg_offset
        |=> reg_rdata_out == $past(general_cfg_reg))
        else $error("configuration read mismatch");
    chk_read_no_effect: assert property (@(posedge clk_in) disable iff (rst_in)
        reg_read_in && !reg_write_in && strap_loaded_reg && !register_reset_out
        |=> $stable(general_cfg_reg) && $stable(address_override_enable_reg))
        else $error("read changed register contents");
endmodule
`default_nettype wire

//--- rtl/main_cfg_pkg.sv
package main_cfg_pkg;
    localparam logic [7:0] own_addr_offset = 8'h00;
    localparam logic [7:0] reset_control_offset = 8'h01;
    localparam logic [7:0] general_cfg_offset = 8'h02;
    localparam int override_bit = 0;
    localparam int addr_lsb = 1;
    localparam int reload_bit = 2;
    localparam int full_reset_bit = 1;
    localparam int soft_reset_bit = 0;
    localparam int clock_lane_bit = 6;
    localparam int lane_lsb = 4;
    localparam int check_code_bit = 1;
    localparam int voltage_bit = 0;
    localparam logic [1:0] lanes_reset = 2'h3;
    localparam logic check_code_reset = 1'b1;
    localparam logic clock_lane_reset = 1'b0;
    localparam logic override_reset = 1'b0;
    localparam logic [7:0] unmapped_value = 8'h00;
endpackage

//--- rtl/strap_capture.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser then a one-shot capture after reset release
module strap_capture #(
    parameter int width = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [width-1:0] strap_in,
    output logic [width-1:0] value_out,
    output logic valid_out
);
    logic [width-1:0] sync1_reg;
    logic [width-1:0] sync2_reg;
    logic [1:0] fill_reg;

    // a zero width leaves nothing to capture, refused at elaboration
    if (width < 1) begin
        $error("strap width must be positive");
    end

    always_ff @(posedge clk_in) begin
        sync1_reg <= strap_in;
        sync2_reg <= sync1_reg;
    end

    // waits two edges so the synchroniser holds real pin levels
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fill_reg <= 2'h0;
            valid_out <= 1'b0;
            value_out <= '0;
        end else begin
            if (fill_reg != 2'h2) begin
                fill_reg <= fill_reg + 2'h1;
            end
            if (fill_reg == 2'h2 && !valid_out) begin
                valid_out <= 1'b1;
                value_out <= sync2_reg;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/reg_host.sv
`timescale 1ns/10ps
`default_nettype none
module reg_host (
    input wire logic clk_in,
    output logic [7:0] addr_out,
    output logic [7:0] data_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        data_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // drives one transfer for one cycle; it is a read whenever the write flag is low
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk_in);
        addr_out = a;
        data_out = d;
        wr_out = w;
        rd_out = ~w;
        @(negedge clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        // released lines never keep the old value
        addr_out = ~a;
        data_out = ~d;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_serializer_main_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serializer_main_config_regs import main_cfg_pkg::*;;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] ha, hd, rdata, m_cfg;
    logic [6:0] strap, act, m_addr;
    logic [1:0] ln;
    logic vs, hw, hr, av, rom, rr, lr, ck, cc, vl, m_ov;
    logic [31:0] lfsr = 32'h2ca27113;
    int err_count = 0;
    int compares = 0;
    always #20 clk_in = ~clk_in;
    reg_host i_reg_host (.clk_in(clk_in), .addr_out(ha), .data_out(hd), .wr_out(hw), .rd_out(hr));
    serializer_main_config_regs i_serializer_main_config_regs (.clk_in(clk_in), .rst_in(rst_in),
        .address_strap_pin_in(strap), .voltage_strap_in(vs), .reg_addr_in(ha),
        .reg_wdata_in(hd), .reg_write_in(hw), .reg_read_in(hr), .reg_rdata_out(rdata),
        .active_bus_address_out(act), .address_valid_out(av), .rom_reload_request_out(rom),
        .register_reset_out(rr), .logic_reset_out(lr), .clock_lane_always_on_out(ck),
        .lane_select_out(ln), .tx_check_code_enable_out(cc), .bus_voltage_low_out(vl));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_reg_host.xfer(a, 8'h00, 1'b0);
        chk("rdata", e, rdata);
    endtask
    task automatic co;
        chk("address", {1'b0, m_ov ? m_addr : strap}, {1'b0, act});
        chk("config", {3'h0, m_cfg[6:4], m_cfg[1:0]}, {3'h0, ck, ln, cc, vl});
    endtask
    // address valid returns a few cycles after reset release or a full register reset, which reapplies the stored straps
    task automatic wv;
        repeat (2) @(negedge clk_in);
        for (int i = 0; i < 20 && av !== 1'b1; i++) @(negedge clk_in);
        chk("valid", 8'h01, {7'h00, av});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic r;
        r = a == reset_control_offset;
        i_reg_host.xfer(a, d, 1'b1);
        chk("pulses", {5'h00, r & d[reload_bit], r & d[full_reset_bit], r & (d[1:0] != 2'b00)},
            {5'h00, rom, rr, lr});
        @(negedge clk_in);
        chk("pulse end", 8'h00, {5'h00, rom, rr, lr});
        if (r & d[full_reset_bit]) chk("valid drop", 8'h00, {7'h00, av});
        if (a == own_addr_offset) m_addr = m_ov ? d[7:1] : strap;
        if (a == own_addr_offset) m_ov = d[override_bit];
        if (a == general_cfg_offset) m_cfg = d;
        if (r & d[full_reset_bit]) m_ov = 1'b0;
        if (r & d[full_reset_bit]) m_cfg = {7'h19, vs};
    endtask
    initial begin
        strap = lfsr[6:0];
        vs = lfsr[8];
        m_cfg = {7'h19, lfsr[8]};
        m_ov = 1'b0;
        m_addr = lfsr[6:0];
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        wv;
        co;
        rd(own_addr_offset, {strap, 1'b0});
        rd(general_cfg_offset, m_cfg);
        rd(general_cfg_offset, m_cfg);
        rd(8'h05, unmapped_value);
        $display("test defaults done");
        for (int i = 0; i < 5; i++) begin
            lfsr = nxt(lfsr);
            wr(own_addr_offset, {lfsr[7:1], 1'b1});
            co;
            rd(own_addr_offset, {m_addr, 1'b1});
        end
        wr(own_addr_offset, 8'h00);
        co;
        $display("test address done");
        for (int j = 0; j < 4; j++) begin
            wr(general_cfg_offset, {1'b0, j[0], j[1], j[1] | j[0], 2'b00, j[1], ~j[0]});
            co;
            rd(general_cfg_offset, m_cfg);
        end
        wr(reset_control_offset, 8'h04);
        rd(reset_control_offset, 8'h00);
        wr(reset_control_offset, 8'h01);
        co;
        rd(general_cfg_offset, m_cfg);
        wr(own_addr_offset, 8'h01);
        wr(reset_control_offset, 8'h02);
        wv;
        co;
        rd(own_addr_offset, {strap, 1'b0});
        wr(general_cfg_offset, 8'h41);
        wr(reset_control_offset, 8'h03);
        wv;
        co;
        $display("test resets done");
        conclude;
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        err_count++;
        conclude;
    end
endmodule
`default_nettype wire
